// *** src/clamp_gain_offset_defines.svh ***
// register offsets, field positions, reset values and codes of the clamp/gain/offset block
`ifndef CLAMP_GAIN_OFFSET_DEFINES_SVH
`define CLAMP_GAIN_OFFSET_DEFINES_SVH

`define REG_CLAMP_START_DELAY 8'h05
`define REG_CLAMP_LENGTH 8'h06
`define REG_RED_FULL_SCALE 8'h08
`define REG_GREEN_FULL_SCALE 8'h09
`define REG_BLUE_FULL_SCALE 8'h0a
`define REG_RED_LEVEL_SHIFT 8'h0b
`define REG_GREEN_LEVEL_SHIFT 8'h0c
`define REG_BLUE_LEVEL_SHIFT 8'h0d
`define REG_SYNC_CLAMP_CONTROL 8'h0f
`define REG_CLAMP_LEVEL_THRESHOLD 8'h10

`define BIT_CLAMP_SOURCE 7
`define BIT_CLAMP_POLARITY 6
`define BIT_SYNC_FROM_GREEN 3
`define BIT_RED_MIDSCALE 1
`define BIT_BLUE_MIDSCALE 2
`define SOG_THRESH_MSB 7
`define SOG_THRESH_LSB 3
`define SYNC_CLAMP_USED_MASK 8'hc8
`define LEVEL_THRESHOLD_USED_MASK 8'hfe

`define RST_CLAMP_START_DELAY 8'h08
`define RST_CLAMP_LENGTH 8'h14
`define RST_FULL_SCALE 8'h80
`define RST_LEVEL_SHIFT 7'h40
`define RST_SYNC_CLAMP_CONTROL 8'h00
`define RST_CLAMP_LEVEL_THRESHOLD 8'h78

`define CODE_GROUND 8'h00
`define CODE_MIDSCALE 8'h80
`define SHIFT_NEG_LIMIT 7'h41
`define SHIFT_CENTRE 7'h40

// serial device address upper six bits, value arbitrary
`define SERIAL_BASE_ADDR 6'h26
`define SERIAL_BITS_PER_BYTE 4'h8

`endif

// *** src/clamp_gain_offset_pkg.sv ***
// types shared by the clamp/gain/offset control block
package clamp_gain_offset_pkg;

    typedef enum logic [1:0] {
        clamp_idle,
        clamp_wait,
        clamp_active
    } clamp_phase_type;

    typedef enum logic [3:0] {
        ser_idle,
        ser_addr,
        ser_ack_addr,
        ser_sub,
        ser_ack_sub,
        ser_write,
        ser_ack_write,
        ser_read,
        ser_read_ack
    } serial_state_type;

endpackage : clamp_gain_offset_pkg

// *** src/serial_register_port.sv ***
// 2-wire serial slave giving byte access to the register file
`timescale 1ns/100ps
`include "clamp_gain_offset_defines.svh"

module serial_register_port
    import clamp_gain_offset_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic addr_sel_in,
    output logic sda_drive_n_out,
    output logic [7:0] reg_addr_out,
    output logic wr_strobe_out,
    output logic [7:0] wr_data_out,
    input wire logic [7:0] rd_data_in
);

    serial_state_type state_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic rw_r;
    logic nack_r;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // line history for edge and start/stop detection
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_prev_r <= scl_in;
            sda_prev_r <= sda_in;
        end
    end

    assign scl_rise = scl_in & ~scl_prev_r;
    assign scl_fall = ~scl_in & scl_prev_r;
    assign start_seen = scl_in & scl_prev_r & sda_prev_r & ~sda_in;
    assign stop_seen = scl_in & scl_prev_r & ~sda_prev_r & sda_in;

    // byte engine: address, sub-address, auto-incrementing data
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_r <= ser_idle;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            sda_drive_n_out <= 1'b1;
            reg_addr_out <= 8'h00;
            wr_strobe_out <= 1'b0;
            wr_data_out <= 8'h00;
        end else begin
            wr_strobe_out <= 1'b0;
            if (start_seen) begin
                state_r <= ser_addr;
                cnt_r <= 4'h0;
                sda_drive_n_out <= 1'b1;
            end else if (stop_seen) begin
                state_r <= ser_idle;
                sda_drive_n_out <= 1'b1;
            end else if (scl_rise) begin
                if (state_r == ser_addr || state_r == ser_sub || state_r == ser_write) begin
                    shift_r <= {shift_r[6:0], sda_in};
                    cnt_r <= cnt_r + 4'h1;
                end else if (state_r == ser_read_ack) begin
                    nack_r <= sda_in;
                end
            end else if (scl_fall) begin
                unique case (state_r)
                    ser_idle: begin
                        sda_drive_n_out <= 1'b1;
                    end
                    ser_addr: begin
                        if (cnt_r == `SERIAL_BITS_PER_BYTE) begin
                            if (shift_r[7:1] == {`SERIAL_BASE_ADDR, addr_sel_in}) begin
                                rw_r <= shift_r[0];
                                sda_drive_n_out <= 1'b0;
                                state_r <= ser_ack_addr;
                            end else begin
                                state_r <= ser_idle;
                            end
                        end
                    end
                    ser_sub: begin
                        if (cnt_r == `SERIAL_BITS_PER_BYTE) begin
                            reg_addr_out <= shift_r;
                            sda_drive_n_out <= 1'b0;
                            state_r <= ser_ack_sub;
                        end
                    end
                    ser_write: begin
                        if (cnt_r == `SERIAL_BITS_PER_BYTE) begin
                            wr_data_out <= shift_r;
                            wr_strobe_out <= 1'b1;
                            sda_drive_n_out <= 1'b0;
                            state_r <= ser_ack_write;
                        end
                    end
                    ser_ack_addr: begin
                        if (rw_r) begin
                            shift_r <= rd_data_in;
                            sda_drive_n_out <= rd_data_in[7];
                            cnt_r <= 4'h1;
                            state_r <= ser_read;
                        end else begin
                            sda_drive_n_out <= 1'b1;
                            cnt_r <= 4'h0;
                            state_r <= ser_sub;
                        end
                    end
                    ser_ack_sub: begin
                        sda_drive_n_out <= 1'b1;
                        cnt_r <= 4'h0;
                        state_r <= ser_write;
                    end
                    ser_ack_write: begin
                        reg_addr_out <= reg_addr_out + 8'h01;
                        sda_drive_n_out <= 1'b1;
                        cnt_r <= 4'h0;
                        state_r <= ser_write;
                    end
                    ser_read: begin
                        if (cnt_r == `SERIAL_BITS_PER_BYTE) begin
                            sda_drive_n_out <= 1'b1;
                            reg_addr_out <= reg_addr_out + 8'h01;
                            state_r <= ser_read_ack;
                        end else begin
                            sda_drive_n_out <= shift_r[6];
                            shift_r <= {shift_r[6:0], 1'b0};
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                    ser_read_ack: begin
                        if (nack_r) begin
                            state_r <= ser_idle;
                        end else begin
                            shift_r <= rd_data_in;
                            sda_drive_n_out <= rd_data_in[7];
                            cnt_r <= 4'h1;
                            state_r <= ser_read;
                        end
                    end
                endcase
            end
        end
    end

endmodule : serial_register_port

// *** src/clamp_gain_offset_control.sv ***
// clamp timing, clamp level, gain, offset and sync slicer settings of a triple video adc
`timescale 1ns/100ps
`include "clamp_gain_offset_defines.svh"

// Summary of operation
// R1: with ground clamping the clamp target code during the clamp interval is 0x00.
// R2: with the clamp source bit at one the clamp follows the external clamp pin.
// R3: the external clamp pin's active level is chosen by bit 6 of sync_clamp_control.
// R4: internal clamp starts the placement count of pixel periods after hsync's trailing edge.
// R5: internal clamp lasts the duration count of pixel periods from register 0x06.
// R6: software should begin with placement 0x08 and duration 0x14.
// R7: a midscale-selected channel clamps to code 0x80 instead of 0x00.
// R8: red and blue have own midscale select bits at bits 1 and 2 of clamp_level_threshold_control.
// R9: three 8-bit full-scale registers sit at 0x08, 0x09, 0x0A for red, green, blue.
// R10: a larger full-scale value widens the input range and lowers contrast.
// R11: three 7-bit offset registers sit at 0x0B, 0x0C, 0x0D for red, green, blue.
// R12: offset moves the level up to 63 lsb either way, step scaling with full scale.
// R13: the sync-on-green slicer threshold is a field of clamp_level_threshold_control.
// R14: sync taken from the green input is always treated as negative polarity.
// R15: placement and duration counters restart on each hsync trailing edge.
// R16: with the clamp source bit at zero the external pin is ignored.
module clamp_gain_offset_control
    import clamp_gain_offset_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic serial_addr_sel_in,
    output logic sda_out,
    output logic sda_drive_n_out,
    input wire logic hsync_in,
    input wire logic green_sync_input_in,
    input wire logic ext_clamp_in,
    output logic clamp_out,
    output logic [7:0] clamp_code_out [3],
    output logic [7:0] full_scale_out [3],
    output logic [6:0] level_shift_out [3],
    output logic [6:0] shift_lsb_out [3],
    output logic [4:0] sog_threshold_out
);

    logic [7:0] reg_addr;
    logic wr_strobe;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] clamp_start_delay_r;
    logic [7:0] clamp_length_r;
    logic [7:0] full_scale_r [3];
    logic [6:0] level_shift_r [3];
    logic [7:0] sync_clamp_control_r;
    logic [7:0] clamp_level_threshold_r;
    logic [2:0] midscale_sel;
    logic [7:0] clamp_code_r [3];
    logic [6:0] shift_lsb_r [3];
    logic clamp_src_ext;
    logic clamp_pol_low;
    logic sync_level;
    logic sync_prev_r;
    logic edge_w;
    clamp_phase_type phase_r;
    logic [7:0] phase_cnt_r;
    logic internal_clamp;
    logic [8:0] since_edge_r;
    logic [8:0] act_run_r;

    serial_register_port u_serial (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .addr_sel_in(serial_addr_sel_in),
        .sda_drive_n_out(sda_drive_n_out),
        .reg_addr_out(reg_addr),
        .wr_strobe_out(wr_strobe),
        .wr_data_out(wr_data),
        .rd_data_in(rd_data)
    );

    // open-drain data pin only ever pulls low
    always_ff @(posedge clk_sys_in) begin
        sda_out <= 1'b0;
    end

    // clamp timing registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            clamp_start_delay_r <= `RST_CLAMP_START_DELAY;
            clamp_length_r <= `RST_CLAMP_LENGTH;
        end else if (wr_strobe) begin
            if (reg_addr == `REG_CLAMP_START_DELAY) begin
                clamp_start_delay_r <= wr_data; // [R4]
            end
            if (reg_addr == `REG_CLAMP_LENGTH) begin
                clamp_length_r <= wr_data; // [R5]
            end
        end
    end

    // control registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sync_clamp_control_r <= `RST_SYNC_CLAMP_CONTROL;
            clamp_level_threshold_r <= `RST_CLAMP_LEVEL_THRESHOLD;
        end else if (wr_strobe) begin
            if (reg_addr == `REG_SYNC_CLAMP_CONTROL) begin
                sync_clamp_control_r <= wr_data & `SYNC_CLAMP_USED_MASK; // [R2] [R3]
            end
            if (reg_addr == `REG_CLAMP_LEVEL_THRESHOLD) begin
                clamp_level_threshold_r <= wr_data & `LEVEL_THRESHOLD_USED_MASK; // [R8] [R13]
            end
        end
    end

    assign clamp_src_ext = sync_clamp_control_r[`BIT_CLAMP_SOURCE];
    assign clamp_pol_low = sync_clamp_control_r[`BIT_CLAMP_POLARITY];
    assign midscale_sel = {clamp_level_threshold_r[`BIT_BLUE_MIDSCALE], 1'b0,
                           clamp_level_threshold_r[`BIT_RED_MIDSCALE]}; // [R8]

    // per-channel full scale, offset and clamp level
    generate
        for (genvar ch = 0; ch < 3; ch++) begin : g_chan
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    full_scale_r[ch] <= `RST_FULL_SCALE;
                    level_shift_r[ch] <= `RST_LEVEL_SHIFT;
                end else if (wr_strobe) begin
                    if (reg_addr == 8'(`REG_RED_FULL_SCALE + ch)) begin
                        full_scale_r[ch] <= wr_data; // [R9] [R10]
                    end
                    if (reg_addr == 8'(`REG_RED_LEVEL_SHIFT + ch)) begin
                        level_shift_r[ch] <= wr_data[6:0]; // [R11]
                    end
                end
            end

            // signed shift, lowest code saturates at minus 63
            always_ff @(posedge clk_sys_in) begin
                if (rst_in) begin
                    shift_lsb_r[ch] <= 7'h00;
                    clamp_code_r[ch] <= `CODE_GROUND;
                end else begin
                    shift_lsb_r[ch] <= (level_shift_r[ch] == 7'h00) ? `SHIFT_NEG_LIMIT :
                                       7'(level_shift_r[ch] - `SHIFT_CENTRE); // [R12]
                    clamp_code_r[ch] <= midscale_sel[ch] ? `CODE_MIDSCALE
                                                         : `CODE_GROUND; // [R1] [R7]
                end
            end

            assign full_scale_out[ch] = full_scale_r[ch];
            assign level_shift_out[ch] = level_shift_r[ch];
            assign shift_lsb_out[ch] = shift_lsb_r[ch];
            assign clamp_code_out[ch] = clamp_code_r[ch];
        end
    endgenerate

    assign sog_threshold_out = clamp_level_threshold_r[`SOG_THRESH_MSB:`SOG_THRESH_LSB]; // [R13]

    // register readback, unmapped reads return zero
    always_comb begin
        unique case (reg_addr)
            `REG_CLAMP_START_DELAY: rd_data = clamp_start_delay_r;
            `REG_CLAMP_LENGTH: rd_data = clamp_length_r;
            `REG_RED_FULL_SCALE: rd_data = full_scale_r[0];
            `REG_GREEN_FULL_SCALE: rd_data = full_scale_r[1];
            `REG_BLUE_FULL_SCALE: rd_data = full_scale_r[2];
            `REG_RED_LEVEL_SHIFT: rd_data = {1'b0, level_shift_r[0]};
            `REG_GREEN_LEVEL_SHIFT: rd_data = {1'b0, level_shift_r[1]};
            `REG_BLUE_LEVEL_SHIFT: rd_data = {1'b0, level_shift_r[2]};
            `REG_SYNC_CLAMP_CONTROL: rd_data = sync_clamp_control_r;
            `REG_CLAMP_LEVEL_THRESHOLD: rd_data = clamp_level_threshold_r;
            default: rd_data = 8'h00;
        endcase
    end

    // green sync is active low, hsync input active high
    assign sync_level = sync_clamp_control_r[`BIT_SYNC_FROM_GREEN] ? ~green_sync_input_in
                                                                   : hsync_in; // [R14]

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sync_prev_r <= 1'b0;
        end else begin
            sync_prev_r <= sync_level;
        end
    end

    assign edge_w = sync_prev_r & ~sync_level;

    // placement then duration counter, restarted every line
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            phase_r <= clamp_idle;
            phase_cnt_r <= 8'h00;
        end else if (edge_w) begin
            phase_cnt_r <= 8'h01; // [R15]
            if (clamp_start_delay_r != 8'h00) begin
                phase_r <= clamp_wait;
            end else if (clamp_length_r != 8'h00) begin
                phase_r <= clamp_active;
            end else begin
                phase_r <= clamp_idle;
            end
        end else begin
            unique case (phase_r)
                clamp_idle: begin
                    phase_cnt_r <= 8'h00;
                end
                clamp_wait: begin
                    if (phase_cnt_r == clamp_start_delay_r) begin // [R4]
                        phase_cnt_r <= 8'h01;
                        phase_r <= (clamp_length_r != 8'h00) ? clamp_active : clamp_idle;
                    end else begin
                        phase_cnt_r <= phase_cnt_r + 8'h01;
                    end
                end
                clamp_active: begin
                    if (phase_cnt_r >= clamp_length_r) begin // [R5]
                        phase_r <= clamp_idle;
                    end else begin
                        phase_cnt_r <= phase_cnt_r + 8'h01;
                    end
                end
                default: begin
                    phase_r <= clamp_idle;
                end
            endcase
        end
    end

    assign internal_clamp = (phase_r == clamp_active);

    // clamp source and polarity
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            clamp_out <= 1'b0;
        end else if (clamp_src_ext) begin
            clamp_out <= ext_clamp_in ^ clamp_pol_low; // [R2] [R3]
        end else begin
            clamp_out <= internal_clamp; // [R16]
        end
    end

    // helper counters for checking
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            since_edge_r <= 9'h000;
            act_run_r <= 9'h000;
        end else begin
            since_edge_r <= edge_w ? 9'h000 :
                            (since_edge_r == 9'h1ff) ? since_edge_r : since_edge_r + 9'h001;
            act_run_r <= (internal_clamp && !edge_w) ? act_run_r + 9'h001 : 9'h000;
        end
    end

    default clocking cb_sys @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    a_ext_clamp_follow: assert property ( // [R2]
        clamp_src_ext && $stable(clamp_src_ext) |=> clamp_out == ($past(ext_clamp_in) ^
                                                                  $past(clamp_pol_low)))
        else $error("clamp output does not follow external pin");

    a_ext_clamp_polarity: assert property ( // [R3]
        clamp_src_ext && clamp_pol_low && !ext_clamp_in ##1 clamp_src_ext |-> clamp_out)
        else $error("active-low external clamp not honoured");

    a_int_pin_ignored: assert property ( // [R16]
        !clamp_src_ext |=> clamp_out == $past(internal_clamp))
        else $error("internal clamp not driving output");

    a_clamp_start_time: assert property ( // [R4]
        $rose(internal_clamp) && $past(phase_r) == clamp_wait
        |-> since_edge_r == {1'b0, clamp_start_delay_r})
        else $error("clamp start placement wrong");

    a_clamp_length_time: assert property ( // [R5]
        $fell(internal_clamp) && !$past(edge_w) && $stable(clamp_length_r)
        |-> $past(act_run_r) == {1'b0, clamp_length_r} - 9'h001)
        else $error("clamp duration wrong");

    a_line_restart: assert property ( // [R15]
        edge_w && clamp_start_delay_r != 8'h00 |=> phase_r == clamp_wait && phase_cnt_r == 8'h01)
        else $error("counter not restarted at trailing edge");

    a_green_ground: assert property ( // [R1]
        !clamp_level_threshold_r[`BIT_RED_MIDSCALE]
        |=> clamp_code_r[0] == `CODE_GROUND && clamp_code_r[1] == `CODE_GROUND)
        else $error("ground clamp target not code zero");

    a_midscale_code: assert property ( // [R7] [R8]
        wr_strobe && reg_addr == `REG_CLAMP_LEVEL_THRESHOLD ##2 !$past(wr_strobe)
        |-> clamp_code_out[0] == ($past(wr_data[`BIT_RED_MIDSCALE], 2) ? `CODE_MIDSCALE
                                                                       : `CODE_GROUND))
        else $error("red clamp level code wrong");

    a_gain_write: assert property ( // [R9]
        wr_strobe && reg_addr == `REG_BLUE_FULL_SCALE |=> full_scale_out[2] == $past(wr_data))
        else $error("blue full scale not written");

    a_shift_range: assert property ( // [R12]
        shift_lsb_r[0] != 7'h40 && shift_lsb_r[2] != 7'h40)
        else $error("offset beyond 63 lsb");

    a_green_negative: assert property ( // [R14]
        edge_w && sync_clamp_control_r[`BIT_SYNC_FROM_GREEN] && $stable(sync_clamp_control_r)
        |-> $rose(green_sync_input_in))
        else $error("green sync not negative polarity");

    a_threshold_write: assert property ( // [R13]
        wr_strobe && reg_addr == `REG_CLAMP_LEVEL_THRESHOLD
        |=> sog_threshold_out == $past(wr_data[`SOG_THRESH_MSB:`SOG_THRESH_LSB]))
        else $error("threshold field not written");

    c_ext_clamp: cover property (clamp_src_ext && clamp_out);
    c_int_pulse: cover property ($fell(internal_clamp) && !clamp_src_ext);
    c_midscale: cover property (clamp_code_out[2] == `CODE_MIDSCALE);
    c_reg_write: cover property (wr_strobe);

endmodule : clamp_gain_offset_control

// *** test/video_source_model.sv ***
// graphics source model: horizontal sync and green sync pulses
`timescale 1ns/100ps
module video_source_model (
    input wire logic clk_in,
    output logic hsync_out,
    output logic green_sync_out
);
    initial begin
        hsync_out = 1'b0;
        green_sync_out = 1'b1;
    end
    // one sync pulse of w clocks, on hsync or on green
    task automatic pulse(input int w, input bit grn);
        @(negedge clk_in);
        if (grn) green_sync_out = 1'b0;
        else hsync_out = 1'b1;
        repeat (w) @(negedge clk_in);
        hsync_out = 1'b0;
        green_sync_out = 1'b1;
    endtask : pulse
endmodule : video_source_model

// *** test/tb_clamp_gain_offset_control.sv ***
// self-checking bench of clamp timing, gain, offset and slicer settings
`timescale 1ns/100ps
`include "clamp_gain_offset_defines.svh"
module tb_clamp_gain_offset_control;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic scl = 1'b1;
    logic sda_m = 1'b1;
    logic ext = 1'b0;
    logic sda_n, hs, gs, clamp;
    logic [7:0] code [3];
    logic [7:0] fs [3];
    logic [6:0] ls [3];
    logic [6:0] sl [3];
    logic [4:0] sog;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int p, l;
    logic [7:0] d;
    logic [7:0] rd;
    always #50 clk_sys_in = ~clk_sys_in;
    video_source_model u_src (.clk_in(clk_sys_in), .hsync_out(hs), .green_sync_out(gs));
    clamp_gain_offset_control u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .scl_in(scl), .sda_in(sda_m & sda_n), .serial_addr_sel_in(1'b0), .sda_out(),
        .sda_drive_n_out(sda_n), .hsync_in(hs), .green_sync_input_in(gs),
        .ext_clamp_in(ext), .clamp_out(clamp), .clamp_code_out(code),
        .full_scale_out(fs), .level_shift_out(ls), .shift_lsb_out(sl),
        .sog_threshold_out(sog));
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [6:0] exp_shift(input logic [6:0] c);
        return (c == 7'h00) ? `SHIFT_NEG_LIMIT : c - `SHIFT_CENTRE;
    endfunction : exp_shift
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask : tick
    task automatic sbit(input logic b);
        sda_m = b;
        tick(2);
        scl = 1'b1;
        tick(3);
        scl = 1'b0;
        tick(1);
    endtask : sbit
    task automatic sbyte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) sbit(b[i]);
        sbit(1'b1);
    endtask : sbyte
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        tick(2);
        sda_m = 1'b0;
        tick(3);
        scl = 1'b0;
        tick(2);
        sbyte({`SERIAL_BASE_ADDR, 2'b00});
        sbyte(a);
        sbyte(v);
        sda_m = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_m = 1'b1;
        tick(4);
    endtask : wreg
    // sub-address write, repeated start, one byte read, nack, stop
    task automatic rreg(input logic [7:0] a, output logic [7:0] v);
        tick(2);
        sda_m = 1'b0;
        tick(3);
        scl = 1'b0;
        tick(2);
        sbyte({`SERIAL_BASE_ADDR, 2'b00});
        sbyte(a);
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_m = 1'b0;
        tick(3);
        scl = 1'b0;
        tick(2);
        sbyte({`SERIAL_BASE_ADDR, 2'b01});
        for (int i = 7; i >= 0; i--) begin
            tick(2);
            scl = 1'b1;
            tick(1);
            v[i] = sda_n;
            tick(2);
            scl = 1'b0;
            tick(1);
        end
        sbit(1'b1);
        sda_m = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_m = 1'b1;
        tick(4);
    endtask : rreg
    task automatic clampchk(input int cp, input int cl, input bit grn);
        u_src.pulse(3, grn);
        for (int k = 0; k < cp + cl + 4; k++) begin
            tick(1);
            chk({7'h0, clamp}, {7'h0, k >= cp + 1 && k < cp + cl + 1});
        end
    endtask : clampchk
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        d = 8'($urandom(83));
        tick(3);
        rst_in = 1'b0;
        tick(2);
        for (int i = 0; i < 3; i++) begin
            chk(fs[i], `RST_FULL_SCALE);
            chk({1'b0, ls[i]}, {1'b0, `RST_LEVEL_SHIFT});
            chk(code[i], `CODE_GROUND);
        end
        chk({3'h0, sog}, 8'h0f);
        for (int n = 0; n < 5; n++) begin
            for (int i = 0; i < 3; i++) begin
                d = (n == 0) ? 8'h00 : 8'($urandom);
                wreg(8'(`REG_RED_FULL_SCALE + i), ~d);
                wreg(8'(`REG_RED_LEVEL_SHIFT + i), {1'b0, d[6:0]});
                chk(fs[i], ~d);
                chk({1'b0, ls[i]}, {1'b0, d[6:0]});
                chk({1'b0, sl[i]}, {1'b0, exp_shift(d[6:0])});
                rreg(8'(`REG_RED_FULL_SCALE + i), rd);
                chk(rd, ~d);
            end
        end
        for (int n = 0; n < 4; n++) begin
            d = {5'($urandom), n[1:0], 1'b0};
            wreg(`REG_CLAMP_LEVEL_THRESHOLD, d);
            chk({3'h0, sog}, {3'h0, d[7:3]});
            chk(code[0], d[1] ? `CODE_MIDSCALE : `CODE_GROUND);
            chk(code[1], `CODE_GROUND);
            chk(code[2], d[2] ? `CODE_MIDSCALE : `CODE_GROUND);
        end
        wreg(`REG_CLAMP_START_DELAY, 8'h08);
        wreg(`REG_CLAMP_LENGTH, 8'h14);
        clampchk(8, 20, 1'b0);
        clampchk(8, 20, 1'b0);
        for (int n = 0; n < 4; n++) begin
            p = (n == 0) ? 0 : $urandom_range(30);
            l = (n == 1) ? 0 : $urandom_range(40, 1);
            wreg(`REG_CLAMP_START_DELAY, 8'(p));
            rreg(`REG_CLAMP_START_DELAY, rd);
            chk(rd, 8'(p));
            wreg(`REG_CLAMP_LENGTH, 8'(l));
            clampchk(p, l, n == 3);
            if (n == 2) wreg(`REG_SYNC_CLAMP_CONTROL, 8'h08);
        end
        for (int pol = 0; pol < 3; pol++) begin
            wreg(`REG_SYNC_CLAMP_CONTROL, {pol < 2, pol[0], 6'h00});
            for (int n = 0; n < 10; n++) begin
                ext = 1'($urandom);
                tick(2);
                chk({7'h0, clamp}, {7'h0, pol < 2 && (ext ^ pol[0])});
            end
        end
        print_verdict();
    end
endmodule : tb_clamp_gain_offset_control
